/* design/uiw_serial_core.sv */
/*
  Serial interface core: receiver with idle-line detection and sleep
  wake-up, a small transmitter, internal loopback and an AXI4-Lite
  register slave. Assumes rx_pin is asynchronous to clock.
*/
// Chosen here: the AXI4-Lite register port and the placing of the registers.
// Summary of operation
// - Idle is ones run of frame length
// - Idle detect on whenever receiver enabled, type-selectable, sets flag
// - Short mode counts every one bit-time
// - Long mode counts only after stop bit
// - Short mode: one extra one after all-ones frame flags idle
// - Idle interrupt when enabled and flag set
// - Status read then data read clears idle
// - Idle rearms only after a received frame
// - Sleep suppresses receiver flags and interrupts
// - Sleep bit writable, hardware clears on wake
// - Wake type zero idle, one address mark
// - Idle wake clears sleep, next frame normal
// - MSB-set frame wakes and is received normally
// - Loopback feeds tx into rx, pin idles high
// - After reset no serial activity until enabled
// - Status read then data write clears tx flags
// - Frame select picks eight or nine data bits
// - Stop bit moves shifter to holding register
// - Status read arms, data read clears flags
`timescale 1ns/100ps
`default_nettype none
module uiw_serial_core #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // AXI4-Lite write channels
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Serial pins and interrupt request
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             irq_req
);
  initial begin
    if (DIV_W < 2 || DIV_W > 16) $error("uiw_serial_core: bad DIV_W");
  end

  // Registers and flags
  uiw_pkg::uiw_ctrl_type ctrl_r, ctrl_nxt;
  logic [DIV_W-1:0] baud_r, baud_nxt;      // Tick divisor
  logic [5:0]  stat_r, stat_nxt;           // Status flags
  logic [5:0]  snap_r, snap_nxt;           // Flags seen at status read
  logic        tx_arm_r, tx_arm_nxt;       // Status read before data write
  logic [8:0]  hold_r, hold_nxt;           // Receive holding register
  logic [8:0]  txd_r, txd_nxt;             // Transmit data register
  logic        idle_arm_r, idle_arm_nxt;   // Idle flag may be set again
  // Bus handshake state
  logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [3:0]  awa_r, awa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0]  ws_r, ws_nxt;
  logic        bv_nxt, rv_nxt, irq_nxt;
  logic [1:0]  br_nxt, rr_nxt;
  logic [31:0] rd_nxt;
  // Receiver state
  uiw_pkg::uiw_rx_state_type rx_st_r, rx_st_nxt;
  logic [3:0]  rph_r, rph_nxt;             // Oversample phase
  logic [3:0]  rbit_r, rbit_nxt;           // Data bits taken
  logic [8:0]  rsh_r, rsh_nxt;             // Receive shifter
  logic [3:0]  ones_r, ones_nxt;           // Run of one bit-times
  // Transmitter state
  logic        tbusy_r, tbusy_nxt;
  logic [3:0]  tph_r, tph_nxt, tleft_r, tleft_nxt;
  logic [10:0] tsh_r, tsh_nxt;
  logic        txp_nxt;
  // Pin synchroniser and tick
  logic        s1_r, s2_r, s3_r, rxs_r, rxs_nxt;
  logic        tick;

  uiw_tick_gen #(.DIV_W(DIV_W)) u_tick (
    .clock   (clock),
    .sys_rst (sys_rst),
    .divisor (baud_r),
    .tick    (tick)
  );

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Local views
  logic        bit_ev, bit_val, frame_ev, stop_ok, idle_det;
  logic        tx_line, rx_in, wr_go, rd_go, asleep;
  logic [3:0]  fsize;
  logic [31:0] cmerge;

  // Next-state logic for bus, registers, receiver and transmitter
  always_comb begin
    ctrl_nxt = ctrl_r;  baud_nxt = baud_r;  stat_nxt = stat_r;
    snap_nxt = snap_r;  tx_arm_nxt = tx_arm_r;  hold_nxt = hold_r;
    txd_nxt = txd_r;  idle_arm_nxt = idle_arm_r;
    aw_got_nxt = aw_got_r;  w_got_nxt = w_got_r;  awa_nxt = awa_r;
    wd_nxt = wd_r;  ws_nxt = ws_r;  bv_nxt = s_axi_bvalid;
    br_nxt = s_axi_bresp;  rv_nxt = s_axi_rvalid;
    rr_nxt = s_axi_rresp;  rd_nxt = s_axi_rdata;
    rx_st_nxt = rx_st_r;  rph_nxt = rph_r;  rbit_nxt = rbit_r;
    rsh_nxt = rsh_r;  ones_nxt = ones_r;  tbusy_nxt = tbusy_r;
    tph_nxt = tph_r;  tleft_nxt = tleft_r;  tsh_nxt = tsh_r;
    bit_ev = 1'b0;  bit_val = 1'b1;  frame_ev = 1'b0;
    stop_ok = 1'b0;  idle_det = 1'b0;
    cmerge = merge({23'h000000, ctrl_r}, wd_r, ws_r);
    asleep = ctrl_r.rx_sleep_bit;
    fsize = ctrl_r.frame_nine ? uiw_pkg::FRAME_LONG
                              : uiw_pkg::FRAME_SHORT;
    // Two flops agreeing update the line level
    rxs_nxt = (s2_r == s3_r) ? s3_r : rxs_r;
    tx_line = tbusy_r ? tsh_r[0] : 1'b1;
    rx_in = ctrl_r.feedback_select ? tx_line : rxs_r;
    txp_nxt = ctrl_r.feedback_select ? 1'b1 : tx_line;

    // Write address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      aw_got_nxt = 1'b1;
      awa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_got_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) bv_nxt = 1'b0;
    if (s_axi_rvalid && s_axi_rready) rv_nxt = 1'b0;
    wr_go = aw_got_r && w_got_r && !s_axi_bvalid;
    rd_go = s_axi_arvalid && s_axi_arready;

    // Transmitter: shifts a loaded frame at the bit rate
    if (!tbusy_r && ctrl_r.transmit_on && !stat_r[uiw_pkg::SB_TXE]) begin
      tbusy_nxt = 1'b1;
      tph_nxt = 4'h0;
      stat_nxt[uiw_pkg::SB_TXE] = 1'b1;
      if (ctrl_r.frame_nine) begin
        tsh_nxt = {1'b1, txd_r, 1'b0};
        tleft_nxt = uiw_pkg::FRAME_LONG;
      end else begin
        tsh_nxt = {2'b11, txd_r[7:0], 1'b0};
        tleft_nxt = uiw_pkg::FRAME_SHORT;
      end
    end else if (tbusy_r && tick) begin
      tph_nxt = tph_r + 4'h1;
      if (tph_r == uiw_pkg::PH_END) begin
        tsh_nxt = {1'b1, tsh_r[10:1]};
        tleft_nxt = tleft_r - 4'h1;
        if (tleft_r == 4'h1) begin
          tbusy_nxt = 1'b0;
          // Done only when nothing else is waiting to go out
          if (stat_r[uiw_pkg::SB_TXE]) stat_nxt[uiw_pkg::SB_TXDONE] = 1'b1;
        end
      end
    end

    // Receiver bit processor, held quiet until enabled
    if (!ctrl_r.rx_on) begin
      rx_st_nxt = uiw_pkg::RX_IDLE;
      rph_nxt = 4'h0;
      ones_nxt = 4'h0;
    end else if (tick) begin
      rph_nxt = rph_r + 4'h1;
      unique case (rx_st_r)
        uiw_pkg::RX_IDLE: begin
          if (!rx_in) begin
            rx_st_nxt = uiw_pkg::RX_START;
            rph_nxt = 4'h0;
          end else if (rph_r == uiw_pkg::PH_END) begin
            bit_ev = 1'b1;              // Idle bit-time of ones
          end
        end
        uiw_pkg::RX_START: begin
          if (rph_r == uiw_pkg::PH_MID) begin
            rph_nxt = 4'h0;
            rbit_nxt = 4'h0;
            // A glitch shorter than half a bit is ignored
            rx_st_nxt = rx_in ? uiw_pkg::RX_IDLE : uiw_pkg::RX_DATA;
            bit_ev = !rx_in;
            bit_val = 1'b0;
          end
        end
        uiw_pkg::RX_DATA: begin
          if (rph_r == uiw_pkg::PH_END) begin
            bit_ev = 1'b1;
            bit_val = rx_in;
            rsh_nxt = {rx_in, rsh_r[8:1]};
            rbit_nxt = rbit_r + 4'h1;
            if (rbit_r == (ctrl_r.frame_nine ? 4'h8 : 4'h7))
              rx_st_nxt = uiw_pkg::RX_STOP;
          end
        end
        uiw_pkg::RX_STOP: begin
          if (rph_r == uiw_pkg::PH_END) begin
            bit_ev = 1'b1;
            bit_val = rx_in;
            frame_ev = 1'b1;
            stop_ok = rx_in;
            rx_st_nxt = uiw_pkg::RX_IDLE;
          end
        end
      endcase
    end

    // Run counter of ones; long mode counts only past the stop bit
    if (bit_ev) begin
      if (!bit_val) begin
        ones_nxt = 4'h0;
      end else if (ctrl_r.idle_type_select &&
                   rx_st_r != uiw_pkg::RX_IDLE) begin
        ones_nxt = 4'h0;
      end else if (ones_r < fsize) begin
        ones_nxt = ones_r + 4'h1;
        idle_det = (ones_r + 4'h1) == fsize;
      end
    end

    // Wake-up clears the sleep bit
    if (asleep && idle_det && !ctrl_r.wake_addr)
      ctrl_nxt.rx_sleep_bit = 1'b0;
    if (asleep && frame_ev && ctrl_r.wake_addr && rsh_nxt[8]) begin
      ctrl_nxt.rx_sleep_bit = 1'b0;
      asleep = 1'b0;              // This frame is received normally
    end

    // Register side effects: status read arms, data access clears
    if (rd_go) begin
      rv_nxt = 1'b1;
      rr_nxt = uiw_pkg::RESP_OKAY;
      rd_nxt = 32'h00000000;
      unique case (s_axi_araddr)
        uiw_pkg::OFS_CTRL:   rd_nxt = {23'h000000, ctrl_r};
        uiw_pkg::OFS_STATUS: begin
          rd_nxt = {26'h0000000, stat_r};
          snap_nxt = stat_r;
          tx_arm_nxt = 1'b1;
        end
        uiw_pkg::OFS_DATA: begin
          rd_nxt = {23'h000000, hold_r};
          // Clear only flags that the armed status read saw
          stat_nxt[5:2] = stat_r[5:2] & ~snap_r[5:2];
          snap_nxt = 6'h00;
        end
        uiw_pkg::OFS_BAUD:   rd_nxt = 32'(baud_r);
        default:             rr_nxt = uiw_pkg::RESP_SLVERR;
      endcase
    end
    if (wr_go) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = uiw_pkg::RESP_OKAY;
      unique case (awa_r)
        uiw_pkg::OFS_CTRL: begin
          ctrl_nxt = cmerge[8:0];
        end
        uiw_pkg::OFS_DATA: begin
          txd_nxt = 9'(merge({23'h000000, txd_r}, wd_r, ws_r));
          if (tx_arm_r) begin
            stat_nxt[uiw_pkg::SB_TXE] = 1'b0;
            stat_nxt[uiw_pkg::SB_TXDONE] = 1'b0;
            tx_arm_nxt = 1'b0;
          end
        end
        uiw_pkg::OFS_BAUD:
          baud_nxt = DIV_W'(merge(32'(baud_r), wd_r, ws_r));
        uiw_pkg::OFS_STATUS: ;
        default: br_nxt = uiw_pkg::RESP_SLVERR;
      endcase
    end

    // Receive flags are set after the clears, so a new receive event is never lost
    if (frame_ev && !asleep) begin
      if (stat_r[uiw_pkg::SB_RXFULL] && !stat_nxt[uiw_pkg::SB_RXFULL]
          || !stat_r[uiw_pkg::SB_RXFULL]) begin
        hold_nxt = ctrl_r.frame_nine ? rsh_nxt : {1'b0, rsh_nxt[8:1]};
        stat_nxt[uiw_pkg::SB_RXFULL] = 1'b1;
        stat_nxt[uiw_pkg::SB_FRM] = !stop_ok;
        idle_arm_nxt = 1'b1;
      end else begin
        stat_nxt[uiw_pkg::SB_OVR] = 1'b1;
      end
    end
    if (idle_det && !ctrl_r.rx_sleep_bit && idle_arm_r) begin
      stat_nxt[uiw_pkg::SB_IDLE] = 1'b1;
      idle_arm_nxt = 1'b0;
    end
    irq_nxt = !ctrl_r.rx_sleep_bit &&
              (ctrl_r.idle_irq_enable && stat_r[uiw_pkg::SB_IDLE] ||
               ctrl_r.rx_irq_enable && stat_r[uiw_pkg::SB_RXFULL]);
  end

  // Register stage for all state except the ready flags
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ctrl_r <= uiw_pkg::CTRL_RST;         baud_r <= DIV_W'(uiw_pkg::BAUD_RST);
      stat_r <= 6'h03;    snap_r <= 6'h00;     tx_arm_r <= 1'b0;
      hold_r <= 9'h000;   txd_r <= 9'h000;     idle_arm_r <= 1'b1;
      aw_got_r <= 1'b0;   w_got_r <= 1'b0;     awa_r <= 4'h0;
      wd_r <= 32'h00000000;                    ws_r <= 4'h0;
      s_axi_bvalid <= 1'b0;  s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;  s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      rx_st_r <= uiw_pkg::RX_IDLE;  rph_r <= 4'h0;  rbit_r <= 4'h0;
      rsh_r <= 9'h000;    ones_r <= 4'h0;      tbusy_r <= 1'b0;
      tph_r <= 4'h0;      tleft_r <= 4'h0;     tsh_r <= 11'h7FF;
      s1_r <= 1'b1;  s2_r <= 1'b1;  s3_r <= 1'b1;  rxs_r <= 1'b1;
      tx_pin <= 1'b1;     irq_req <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;  baud_r <= baud_nxt;  stat_r <= stat_nxt;
      snap_r <= snap_nxt;  tx_arm_r <= tx_arm_nxt;  hold_r <= hold_nxt;
      txd_r <= txd_nxt;    idle_arm_r <= idle_arm_nxt;
      aw_got_r <= aw_got_nxt;  w_got_r <= w_got_nxt;  awa_r <= awa_nxt;
      wd_r <= wd_nxt;      ws_r <= ws_nxt;
      s_axi_bvalid <= bv_nxt;  s_axi_bresp <= br_nxt;
      s_axi_rvalid <= rv_nxt;  s_axi_rresp <= rr_nxt;
      s_axi_rdata <= rd_nxt;
      rx_st_r <= rx_st_nxt;  rph_r <= rph_nxt;  rbit_r <= rbit_nxt;
      rsh_r <= rsh_nxt;    ones_r <= ones_nxt;  tbusy_r <= tbusy_nxt;
      tph_r <= tph_nxt;    tleft_r <= tleft_nxt;  tsh_r <= tsh_nxt;
      // Three-flop pin synchroniser; the first flop feeds only the second
      s1_r <= rx_pin;  s2_r <= s1_r;  s3_r <= s2_r;  rxs_r <= rxs_nxt;
      tx_pin <= txp_nxt;   irq_req <= irq_nxt;
    end
  end

  // Ready flags are registered: low while a transfer or its response
  // is pending, so no second write is taken under an open response
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_got_nxt && !bv_nxt;
      s_axi_wready  <= !w_got_nxt && !bv_nxt;
      s_axi_arready <= !rv_nxt && !rd_go;
    end
  end
endmodule
`default_nettype wire

/* design/uiw_pkg.sv */
/*
  Shared constants and types of the serial receiver support block:
  register offsets, bit positions, reset values and frame timing.
  Assumes a 32-bit AXI4-Lite register bus and a 16x bit-time tick.
*/
`default_nettype none
package uiw_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_DATA   = 4'h8;
  localparam logic [3:0] OFS_BAUD   = 4'hC;
  // Control field positions
  localparam int CB_RX_ON   = 0;
  localparam int CB_TX_ON   = 1;
  localparam int CB_LONGFR  = 2;
  localparam int CB_ILT     = 3;
  localparam int CB_IDLE_IRQ_ENABLE    = 4;
  localparam int CB_SLEEP   = 5;
  localparam int CB_WAKE    = 6;
  localparam int CB_LOOP    = 7;
  localparam int CB_RIE     = 8;
  // Status field positions
  localparam int SB_TXE     = 0;
  localparam int SB_TXDONE  = 1;
  localparam int SB_RXFULL  = 2;
  localparam int SB_IDLE    = 3;
  localparam int SB_OVR     = 4;
  localparam int SB_FRM     = 5;
  // Reset values
  localparam logic [8:0]  CTRL_RST = 9'h000;
  localparam logic [15:0] BAUD_RST = 16'h0001;
  // Frame timing in bit-times, and oversampling phases
  localparam logic [3:0] FRAME_SHORT = 4'hA;
  localparam logic [3:0] FRAME_LONG  = 4'hB;
  localparam logic [3:0] PH_MID      = 4'h7;
  localparam logic [3:0] PH_END      = 4'hF;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Control register carrier
  typedef struct packed {
    logic rx_irq_enable;
    logic feedback_select;
    logic wake_addr;
    logic rx_sleep_bit;
    logic idle_irq_enable;
    logic idle_type_select;
    logic frame_nine;
    logic transmit_on;
    logic rx_on;
  } uiw_ctrl_type;
  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } uiw_rx_state_type;
endpackage
`default_nettype wire

/* design/uiw_tick_gen.sv */
/*
  Divider producing a one-cycle enable at sixteen times the bit rate.
  Assumes the divisor is held stable by software while a frame runs.
*/
`timescale 1ns/100ps
`default_nettype none
module uiw_tick_gen #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // Divisor and tick
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick
);
  initial begin
    if (DIV_W < 2) $error("uiw_tick_gen: DIV_W too small");
  end

  logic [DIV_W-1:0] cnt_r;    // Down counter
  logic [DIV_W-1:0] cnt_nxt;
  logic             tick_nxt;

  // Reload when the count is one or zero; a zero divisor behaves as one
  always_comb begin
    tick_nxt = 1'b0;
    cnt_nxt  = cnt_r - 1'b1;
    if (cnt_r <= 1) begin
      tick_nxt = 1'b1;
      cnt_nxt  = divisor;
    end
  end

  // Register stage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick  <= tick_nxt;
    end
  end
endmodule
`default_nettype wire

/* tb/uiw_far_tx.sv */
/*
  Far-end serial sender model that drives the receiver's line.
  Assumes 16 clocks per bit-time (divisor 1) and an idle-high line.
*/
`timescale 1ns/100ps
`default_nettype none
module uiw_far_tx #(
  parameter int BIT_CLKS = 16  // Clocks per bit-time
) (
  // Clock
  input  wire logic clock,
  // Serial line towards the receiver
  output logic      line
);
  // Mark level until the first frame
  initial line = 1'b1;
  // Hold one bit for a full bit-time, changed just after an edge
  task automatic put_bit(input logic b);
    line <= b;
    repeat (BIT_CLKS) @(posedge clock);
  endtask
  // Start bit, data LSB first, stop bit, then gap bit-times of mark.
  // Gap 0 keeps frames of one message back to back a gap of a
  // frame or more separates messages an address frame has its
  // top data bit set
  task automatic send(input logic [8:0] d, input logic nine,
                      input int gap);
    put_bit(1'b0);
    for (int i = 0; i < 9; i++) begin
      if (i < 8 || nine) put_bit(d[i]);
    end
    repeat (gap + 1) put_bit(1'b1);
  endtask
endmodule
`default_nettype wire

/* tb/uiw_serial_core_chk.sv */
/*
  Port checker for the serial core, bound to every instance.
  Assumes one clock domain and a control shadow snooped from the bus.
*/
`timescale 1ns/100ps
`default_nettype none
module uiw_serial_core_chk (
  // Clock and reset
  input wire logic        clock,
  input wire logic        sys_rst,
  // Register bus
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  // Pins
  input wire logic        tx_pin,
  input wire logic        irq_req
);
  logic [3:0]  wa_r;   // Last write address taken
  logic [31:0] wd_r;   // Last write data taken
  logic        bv_r;   // Response valid one cycle ago
  logic [8:0]  ctl_r;  // Shadow of the control register
  logic        on_r;   // Transmitter enabled at least once
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Catch both write halves, whichever comes first
  always_ff @(posedge clock) begin
    if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata;
  end
  // Commit on the first response cycle, one clock after the core's control register changes
  always_ff @(posedge clock) begin
    bv_r <= s_axi_bvalid;
    if (sys_rst) begin
      ctl_r <= uiw_pkg::CTRL_RST;
      on_r  <= 1'b0;
    end else if (s_axi_bvalid && !bv_r && wa_r == uiw_pkg::OFS_CTRL) begin
      ctl_r <= wd_r[8:0];
      on_r  <= on_r | wd_r[uiw_pkg::CB_TX_ON];
    end
  end
  property p_rst_quiet;
    disable iff (1'b0) $fell(sys_rst) |-> tx_pin && !irq_req;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("pin or request active after reset");
  property p_never_on;
    !on_r |-> tx_pin;
  endproperty
  a_never_on: assert property (p_never_on)
    else $error("line moved before transmitter enabled");
  property p_loop_pin;
    ctl_r[uiw_pkg::CB_LOOP] && $past(ctl_r[uiw_pkg::CB_LOOP]) |-> tx_pin;
  endproperty
  a_loop_pin: assert property (p_loop_pin)
    else $error("pin left mark level in loopback");
  property p_irq_cause;
    $rose(irq_req) |-> ctl_r[uiw_pkg::CB_IDLE_IRQ_ENABLE] || ctl_r[uiw_pkg::CB_RIE];
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("request raised with no enable set");
  property p_sleep_quiet;
    $rose(ctl_r[uiw_pkg::CB_SLEEP]) |-> ##[0:2] !irq_req;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet)
    else $error("request kept while asleep");
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after)
    else $error("write response late");
  property p_r_after;
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after)
    else $error("read data late");
  property p_b_excl;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_b_excl: assert property (p_b_excl)
    else $error("new address accepted during response");
  property p_r_excl;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_excl: assert property (p_r_excl)
    else $error("new read accepted during data");
endmodule
bind uiw_serial_core uiw_serial_core_chk CHK (.clock, .sys_rst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .tx_pin, .irq_req);
`default_nettype wire

/* tb/tb_top.sv */
/*
  Self-checking bench: register bus master, far sender, idle, wake
  and loopback scenarios. Assumes divisor 1, i.e. 16 clocks a bit.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [3:0] CT = uiw_pkg::OFS_CTRL, ST = uiw_pkg::OFS_STATUS;
  localparam logic [3:0] DT = uiw_pkg::OFS_DATA, BD = uiw_pkg::OFS_BAUD;
  localparam logic [31:0] RXO = 32'h1 << uiw_pkg::CB_RX_ON,
    TXO = 32'h1 << uiw_pkg::CB_TX_ON, NIN = 32'h1 << uiw_pkg::CB_LONGFR,
    LNG = 32'h1 << uiw_pkg::CB_ILT, ILI = 32'h1 << uiw_pkg::CB_IDLE_IRQ_ENABLE,
    SLP = 32'h1 << uiw_pkg::CB_SLEEP, WAK = 32'h1 << uiw_pkg::CB_WAKE,
    LPB = 32'h1 << uiw_pkg::CB_LOOP;
  logic        clock = 1'b0, sys_rst = 1'b1;
  logic [3:0]  s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rdat;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic        s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, tx_pin, irq_req;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic   rx_pin;              // Driven by the far sender
  int          fails = 0, tests_run = 0;
  logic [7:0]  rnd = 8'h5A;         // Random stream, fixed seed
  uiw_serial_core DUT (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_pin, .tx_pin,
    .irq_req);
  uiw_far_tx #(.BIT_CLKS(16)) FAR (.clock, .line(rx_pin));
  // 5 ns period
  always #2.5 clock = ~clock;
  // Next value of the random stream
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Expected status word: tx flags idle-set plus rx full and idle
  function automatic logic [31:0] st(input logic f, input logic i);
    return 32'h3 | (32'(f) << uiw_pkg::SB_RXFULL)
                 | (32'(i) << uiw_pkg::SB_IDLE);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, uiw_pkg::RESP_OKAY);
    @(posedge clock);
  endtask
  // Read into rdat; response code checked by the caller if needed
  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rdat = s_axi_rdata;
    @(posedge clock);
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask
  // Watchdog well beyond the expected few thousand cycles
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    complete_run();
  end
  initial begin
    logic [8:0] b;
    logic       nine, lng;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rdc(ST, st(0, 0));
    rdc(CT, 32'h0);
    rdc(BD, 32'(uiw_pkg::BAUD_RST));
    wr(ST, 32'hFFFFFFFF);
    rdc(ST, st(0, 0));
    rdc(4'h2, 32'h0);
    chk(s_axi_rresp, uiw_pkg::RESP_SLVERR);
    // All-ones frame in every size and idle type
    for (int m = 0; m < 4; m++) begin
      nine = m[0];
      lng = m[1];
      wr(CT, RXO | ILI | (nine ? NIN : 0) | (lng ? LNG : 0));
      FAR.send(9'h1FF, nine, 0);
      rdc(ST, st(1, 0));
      repeat (28) @(posedge clock);
      rdc(ST, st(1, !lng));
      repeat (nine ? 176 : 160) @(posedge clock);
      rdc(ST, st(1, 1));
      chk(irq_req, 1'b1);
      rdc(DT, nine ? 32'h1FF : 32'hFF);
      rdc(ST, st(0, 0));
      chk(irq_req, 1'b0);
      repeat (400) @(posedge clock);
      rdc(ST, st(0, 0));
    end
    // Address-mark wake: plain frame ignored, marked frame wakes
    wr(CT, RXO | ILI | SLP | WAK);
    FAR.send(9'h012, 1'b0, 12);
    rdc(ST, st(0, 0));
    rdc(CT, RXO | ILI | SLP | WAK);
    rnd = nx(rnd);
    b = {1'b0, rnd | 8'h80};
    FAR.send(b, 1'b0, 0);
    rdc(CT, RXO | ILI | WAK);
    rdc(ST, st(1, 0));
    rdc(DT, 32'(b));
    // Rest of the message back to back
    for (int i = 0; i < 3; i++) begin
      rnd = nx(rnd);
      b = {1'b0, rnd & 8'hFE};
      FAR.send(b, 1'b0, 0);
      rdc(ST, st(1, 0));
      rdc(DT, 32'(b));
    end
    repeat (200) @(posedge clock);
    rd(ST);
    rd(DT);
    // Idle-line wake: frame dropped, idle frame wakes, next one kept
    wr(CT, RXO | SLP);
    FAR.send(9'h055, 1'b0, 12);
    rdc(CT, RXO);
    rdc(ST, st(0, 0));
    rnd = nx(rnd);
    b = {1'b0, rnd & 8'hFE};
    FAR.send(b, 1'b0, 0);
    rdc(ST, st(1, 0));
    rdc(DT, 32'(b));
    // Loopback with the far line carrying other data meanwhile
    wr(CT, RXO | TXO);
    wr(CT, RXO | TXO | LPB);
    rd(ST);
    rnd = nx(rnd);
    wr(DT, 32'(rnd));
    rd(ST);
    chk(32'(rdat[uiw_pkg::SB_TXDONE]), 32'h0);
    fork
      FAR.send({1'b0, ~rnd}, 1'b0, 0);
    join_none
    chk(tx_pin, 1'b1);
    repeat (176) @(posedge clock);
    rd(ST);
    chk(32'(rdat[uiw_pkg::SB_RXFULL]), 32'h1);
    chk(32'(rdat[uiw_pkg::SB_TXDONE]), 32'h1);
    rdc(DT, 32'(rnd));
    wr(CT, RXO | TXO);
    // Second reset in mid-run
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    rdc(CT, 32'h0);
    rdc(ST, st(0, 0));
    complete_run();
  end
endmodule
`default_nettype wire
